//--- rtl/evctl_pkg.sv
// package: register map, field layout and types of the trace event control block
package evctl_pkg;
	// register offsets (chosen, byte addresses)
	localparam logic [11:0] OFS_EVENT_CTRL = 12'h000;
	localparam logic [11:0] OFS_EXTIN_SEL = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	// behaviour control fields
	localparam int LPO_BIT = 12;
	localparam int BUS_TRIG_BIT = 11;
	localparam int DATA_EN_BIT = 4;
	localparam int INST_EN_LSB = 0;
	localparam int INST_EN_W = 4;
	// selector fields
	localparam int SEL_W = 8;
	localparam int SEL_NUM = 4;
	// bus trigger
	localparam logic [6:0] TRIG_ATID = 7'h7d;
	localparam int ID_W = 7;
	localparam int ATDATA_W = 32;
	// capability defaults (plain choices)
	localparam logic [2:0] DEF_EVENT_COUNT = 3'h3;
	localparam logic [3:0] DEF_RSPAIR_COUNT = 4'h1;
	localparam logic [2:0] DEF_SEL_COUNT = 3'h4;
	localparam logic [8:0] DEF_EXTIN_COUNT = 9'h100;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [3:0] event_hit;
		logic overflow;
		logic unit_busy;
		logic low_power_req;
	} trace_in_t;

	typedef enum logic [0:0] {TRIG_IDLE, TRIG_PEND} trig_state_t;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] sel;
		logic [31:0] rdata;
		trig_state_t trig;
		logic atvalid;
		logic [6:0] atid;
		logic [31:0] atdata;
		logic [3:0] inst_event;
		logic data_event;
		logic lp_allow;
		logic dropped;
	} state_t;
endpackage

//--- rtl/trace_event_ctrl.sv
// trace event behaviour control, external input select and bus trigger
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
// ----------------------------------------------------------------
// What this block does
// - behaviour control is a 32-bit read-write register
// - writes dropped while unit busy
// - override bit twelve blocks low-power entry effects
// - override bit reads zero when unsupported
// - event zero with bit eleven sends trigger
// - trigger data carries trace id, zero-extended
// - trigger may precede its buffered trace
// - first event triggers, repeats merged while pending
// - overflow never suppresses the trigger
// - trigger enable reads zero when unsupported
// - data event enable drives data stream event
// - data enable exists only with data trace
// - each instruction enable bit gates its event
// - only counted instruction enables are implemented
// - input select register exists with selectors
// - four 8-bit selector fields name external inputs
// - selector present per reported selector count
// - selector width limited to index input count
// - enables act on selected events zero to three
// ----------------------------------------------------------------
module trace_event_ctrl
	import evctl_pkg::*;
#(
	parameter logic LPO_SUPPORT = 1'b1,
	parameter logic TRIG_SUPPORT = 1'b1,
	parameter logic DATA_SUPPORT = 1'b1,
	parameter logic [2:0] EVENT_COUNT = DEF_EVENT_COUNT,
	parameter logic [3:0] RSPAIR_COUNT = DEF_RSPAIR_COUNT,
	parameter logic [2:0] SEL_COUNT = DEF_SEL_COUNT,
	parameter logic [8:0] EXTIN_COUNT = DEF_EXTIN_COUNT
)
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// register port
	input evctl_pkg::reg_req_t REG_REQ,
	output logic [31:0] REG_RDATA,
	// trace unit side
	input evctl_pkg::trace_in_t TRACE_IN,
	input wire logic [6:0] TRACE_SOURCE_ID,
	output logic [3:0] INST_EVENT,
	output logic DATA_EVENT,
	output logic LOW_POWER_ALLOW,
	output logic [31:0] EXTIN_SELECT,
	// trace bus trigger
	output logic ATVALID,
	input wire logic ATREADY,
	output logic [6:0] ATID,
	output logic [31:0] ATDATA
);
	import evctl_pkg::*;

	// ----------------------------------------------------------------
	// implemented-bit masks
	// ----------------------------------------------------------------
	function automatic logic [31:0] ctrl_mask();
		logic [31:0] m;
		m = ZERO32;
		m[LPO_BIT] = LPO_SUPPORT;
		m[BUS_TRIG_BIT] = TRIG_SUPPORT;
		m[DATA_EN_BIT] = DATA_SUPPORT && (RSPAIR_COUNT != 4'h0);
		for (int i = 0; i < INST_EN_W; i++)
		begin
			// event count field encodes events minus one
			m[INST_EN_LSB + i] = (RSPAIR_COUNT != 4'h0) && (i <= int'(EVENT_COUNT));
		end
		return m;
	endfunction

	function automatic logic [31:0] sel_mask();
		logic [31:0] m;
		logic [SEL_W-1:0] f;
		m = ZERO32;
		f = '0;
		for (int b = 0; b < SEL_W; b++)
		begin
			f[b] = ((9'h001 << b) < EXTIN_COUNT);
		end
		for (int s = 0; s < SEL_NUM; s++)
		begin
			if (int'(SEL_COUNT) > s)
			begin
				m[s*SEL_W +: SEL_W] = f;
			end
		end
		return m;
	endfunction

	localparam logic [31:0] CTRL_MASK = ctrl_mask();
	localparam logic [31:0] SEL_MASK = sel_mask();

	// ----------------------------------------------------------------
	// register decode used by the checks; the update logic uses rd_hit only to clear the merge flag
	// ----------------------------------------------------------------
	function automatic logic wr_hit(input reg_req_t r, input logic busy, input logic [11:0] a);
		return r.wr && !busy && (r.addr == a);
	endfunction

	function automatic logic rd_hit(input reg_req_t r, input logic [11:0] a);
		return r.rd && (r.addr == a);
	endfunction

	state_t s_q;
	state_t s_d;
	logic wr_ok;
	logic ev0;

	always_comb
	begin
		s_d = s_q;
		// ----------------------------------------------------------------
		// register writes
		// ----------------------------------------------------------------
		// leaves ordering to software; busy writes are silently lost
		wr_ok = REG_REQ.wr && !TRACE_IN.unit_busy;
		if (wr_ok && REG_REQ.addr == OFS_EVENT_CTRL)
		begin
			s_d.ctrl = REG_REQ.wdata & CTRL_MASK;
		end
		if (wr_ok && REG_REQ.addr == OFS_EXTIN_SEL)
		begin
			s_d.sel = REG_REQ.wdata & SEL_MASK;
		end
		// ----------------------------------------------------------------
		// register reads, data one cycle later
		// ----------------------------------------------------------------
		s_d.rdata = ZERO32;
		if (REG_REQ.rd)
		begin
			case (REG_REQ.addr)
				OFS_EVENT_CTRL: s_d.rdata = s_q.ctrl;
				OFS_EXTIN_SEL: s_d.rdata = s_q.sel;
				OFS_STATUS: s_d.rdata = {30'h0, s_q.dropped, s_q.atvalid};
				default: s_d.rdata = ZERO32;
			endcase
		end
		// ----------------------------------------------------------------
		// event elements
		// ----------------------------------------------------------------
		s_d.inst_event = TRACE_IN.event_hit & s_q.ctrl[INST_EN_LSB +: INST_EN_W];
		s_d.data_event = TRACE_IN.event_hit[0] & s_q.ctrl[DATA_EN_BIT];
		s_d.lp_allow = !s_q.ctrl[LPO_BIT];
		// ----------------------------------------------------------------
		// bus trigger; overflow is deliberately not looked at
		// ----------------------------------------------------------------
		ev0 = TRACE_IN.event_hit[0] && s_q.ctrl[BUS_TRIG_BIT];
		case (s_q.trig)
			TRIG_IDLE:
			begin
				if (ev0)
				begin
					s_d.trig = TRIG_PEND;
					s_d.atvalid = 1'b1;
					s_d.atid = TRIG_ATID;
					s_d.atdata = {{(ATDATA_W-ID_W){1'b0}}, TRACE_SOURCE_ID};
				end
			end
			TRIG_PEND:
			begin
				// repeats while waiting merge into one trigger
				if (ev0)
				begin
					s_d.dropped = 1'b1;
				end
				if (ATREADY)
				begin
					s_d.trig = TRIG_IDLE;
					s_d.atvalid = 1'b0;
					s_d.atid = 7'h00;
					s_d.atdata = ZERO32;
				end
			end
			default:
			begin
				s_d.trig = TRIG_IDLE;
				s_d.atvalid = 1'b0;
			end
		endcase
		if (rd_hit(REG_REQ, OFS_STATUS) && !(s_q.trig == TRIG_PEND && ev0))
		begin
			s_d.dropped = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign REG_RDATA = s_q.rdata;
	assign INST_EVENT = s_q.inst_event;
	assign DATA_EVENT = s_q.data_event;
	assign LOW_POWER_ALLOW = s_q.lp_allow;
	assign EXTIN_SELECT = s_q.sel;
	assign ATVALID = s_q.atvalid;
	assign ATID = s_q.atid;
	assign ATDATA = s_q.atdata;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence trig_fire;
		s_q.trig == TRIG_IDLE && TRACE_IN.event_hit[0] && s_q.ctrl[BUS_TRIG_BIT];
	endsequence
	sequence trig_out;
		ATVALID && ATID == TRIG_ATID;
	endsequence

	a_trig_start: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		trig_fire |=> trig_out) else $error("trigger not raised");
	a_trig_data: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		trig_fire |=> ATDATA == {{(ATDATA_W-ID_W){1'b0}}, $past(TRACE_SOURCE_ID)})
		else $error("trigger data wrong");
	a_trig_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ATVALID && !ATREADY |=> ATVALID && $stable(ATDATA)) else $error("trigger dropped early");
	a_trig_release: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		ATVALID && ATREADY |=> !ATVALID) else $error("trigger not released");
	a_busy_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		REG_REQ.wr && TRACE_IN.unit_busy |=> $stable(s_q.ctrl) && $stable(s_q.sel))
		else $error("busy write taken");
	a_ctrl_mask: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(s_q.ctrl & ~CTRL_MASK) == ZERO32) else $error("unimplemented control bit set");
	a_sel_mask: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(s_q.sel & ~SEL_MASK) == ZERO32) else $error("unimplemented selector bit set");
	a_inst_event: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		##1 INST_EVENT == ($past(TRACE_IN.event_hit) & $past(s_q.ctrl[INST_EN_LSB +: INST_EN_W])))
		else $error("instruction event mismatch");
	a_data_event: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		TRACE_IN.event_hit[0] && s_q.ctrl[DATA_EN_BIT] |=> DATA_EVENT) else $error("no data event");
	a_low_power: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		s_q.ctrl[LPO_BIT] |=> !LOW_POWER_ALLOW) else $error("override ignored");

	// ----------------------------------------------------------------
	// register port and trigger sequences
	// ----------------------------------------------------------------
	sequence ctrl_write;
		wr_hit(REG_REQ, TRACE_IN.unit_busy, OFS_EVENT_CTRL);
	endsequence
	sequence sel_write;
		wr_hit(REG_REQ, TRACE_IN.unit_busy, OFS_EXTIN_SEL);
	endsequence
	sequence status_read;
		rd_hit(REG_REQ, OFS_STATUS);
	endsequence
	sequence trig_wait;
		ATVALID && !ATREADY;
	endsequence
	sequence trig_repeat;
		s_q.trig == TRIG_PEND && TRACE_IN.event_hit[0] && s_q.ctrl[BUS_TRIG_BIT];
	endsequence

	// ----------------------------------------------------------------
	// register port checks
	// ----------------------------------------------------------------
	property p_ctrl_write;
		@(posedge CLK_SYS) disable iff (!RST_N)
		ctrl_write |=> s_q.ctrl == ($past(REG_REQ.wdata) & CTRL_MASK);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write not taken");
	property p_ctrl_keep;
		@(posedge CLK_SYS) disable iff (!RST_N)
		!wr_hit(REG_REQ, TRACE_IN.unit_busy, OFS_EVENT_CTRL) |=> $stable(s_q.ctrl);
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep)
		else $error("control changed without write");
	property p_sel_write;
		@(posedge CLK_SYS) disable iff (!RST_N)
		sel_write |=> s_q.sel == ($past(REG_REQ.wdata) & SEL_MASK);
	endproperty
	a_sel_write: assert property (p_sel_write)
		else $error("select write not taken");
	property p_sel_keep;
		@(posedge CLK_SYS) disable iff (!RST_N)
		!wr_hit(REG_REQ, TRACE_IN.unit_busy, OFS_EXTIN_SEL) |=> $stable(s_q.sel);
	endproperty
	a_sel_keep: assert property (p_sel_keep)
		else $error("select changed without write");
	property p_read_ctrl;
		@(posedge CLK_SYS) disable iff (!RST_N)
		rd_hit(REG_REQ, OFS_EVENT_CTRL) |=> REG_RDATA == $past(s_q.ctrl);
	endproperty
	a_read_ctrl: assert property (p_read_ctrl)
		else $error("control read wrong");
	property p_read_sel;
		@(posedge CLK_SYS) disable iff (!RST_N)
		rd_hit(REG_REQ, OFS_EXTIN_SEL) |=> REG_RDATA == $past(s_q.sel);
	endproperty
	a_read_sel: assert property (p_read_sel)
		else $error("select read wrong");
	property p_read_status;
		@(posedge CLK_SYS) disable iff (!RST_N)
		status_read |=> REG_RDATA == 32'({$past(s_q.dropped), $past(ATVALID)});
	endproperty
	a_read_status: assert property (p_read_status)
		else $error("status read wrong");
	property p_rdata_idle;
		@(posedge CLK_SYS) disable iff (!RST_N)
		!REG_REQ.rd |=> REG_RDATA == ZERO32;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data without read");
	property p_drop_clear;
		@(posedge CLK_SYS) disable iff (!RST_N)
		rd_hit(REG_REQ, OFS_STATUS)
		&& !(s_q.trig == TRIG_PEND && TRACE_IN.event_hit[0] && s_q.ctrl[BUS_TRIG_BIT]) |=> !s_q.dropped;
	endproperty
	a_drop_clear: assert property (p_drop_clear)
		else $error("merge flag not cleared");
	property p_drop_keep;
		@(posedge CLK_SYS) disable iff (!RST_N)
		s_q.dropped && !rd_hit(REG_REQ, OFS_STATUS) |=> s_q.dropped;
	endproperty
	a_drop_keep: assert property (p_drop_keep)
		else $error("merge flag lost");

	// ----------------------------------------------------------------
	// trigger and event checks
	// ----------------------------------------------------------------
	property p_drop_set;
		@(posedge CLK_SYS) disable iff (!RST_N)
		trig_repeat |=> s_q.dropped;
	endproperty
	a_drop_set: assert property (p_drop_set)
		else $error("merged event not flagged");
	property p_trig_merge;
		@(posedge CLK_SYS) disable iff (!RST_N)
		trig_wait ##0 trig_repeat |=> trig_out;
	endproperty
	a_trig_merge: assert property (p_trig_merge)
		else $error("pending trigger lost on repeat");
	property p_trig_overflow;
		@(posedge CLK_SYS) disable iff (!RST_N)
		TRACE_IN.overflow ##0 trig_fire |=> trig_out;
	endproperty
	a_trig_overflow: assert property (p_trig_overflow)
		else $error("trigger lost in overflow");
	property p_trig_off;
		@(posedge CLK_SYS) disable iff (!RST_N)
		!s_q.ctrl[BUS_TRIG_BIT] && !ATVALID |=> !ATVALID;
	endproperty
	a_trig_off: assert property (p_trig_off)
		else $error("trigger while disabled");
	property p_trig_idle_bus;
		@(posedge CLK_SYS) disable iff (!RST_N)
		!ATVALID |-> ATID == '0 && ATDATA == ZERO32;
	endproperty
	a_trig_idle_bus: assert property (p_trig_idle_bus)
		else $error("trigger bus not quiet");
	property p_trig_id_hold;
		@(posedge CLK_SYS) disable iff (!RST_N)
		trig_wait |=> $stable(ATID);
	endproperty
	a_trig_id_hold: assert property (p_trig_id_hold)
		else $error("trigger id changed while waiting");
	property p_data_quiet;
		@(posedge CLK_SYS) disable iff (!RST_N)
		!(TRACE_IN.event_hit[0] && s_q.ctrl[DATA_EN_BIT]) |=> !DATA_EVENT;
	endproperty
	a_data_quiet: assert property (p_data_quiet)
		else $error("spurious data event");
	property p_inst_quiet;
		@(posedge CLK_SYS) disable iff (!RST_N)
		TRACE_IN.event_hit == '0 |=> INST_EVENT == '0;
	endproperty
	a_inst_quiet: assert property (p_inst_quiet)
		else $error("spurious instruction event");
	property p_low_power_on;
		@(posedge CLK_SYS) disable iff (!RST_N)
		RST_N && !s_q.ctrl[LPO_BIT] |=> LOW_POWER_ALLOW;
	endproperty
	a_low_power_on: assert property (p_low_power_on)
		else $error("low power not allowed");
endmodule // trace_event_ctrl

//--- bench/trace_sink_model.sv
// trace bus sink model that accepts one beat after a programmable stall
`timescale 1ns/1ns
module trace_sink_model
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// trace bus
	input wire logic at_valid,
	output logic at_ready,
	input wire logic [6:0] at_id,
	input wire logic [31:0] at_data,
	// stall span and record of accepted beats
	input wire logic [3:0] stall,
	output int n_got,
	output logic [6:0] got_id,
	output logic [31:0] got_data
);
	logic [3:0] wait_q;
	// ready comes late on purpose: the source has to hold its beat
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			at_ready <= 1'b0;
			wait_q <= 4'h0;
			n_got <= 0;
		end
		else if (at_valid && at_ready)
		begin
			n_got <= n_got + 1;
			got_id <= at_id;
			got_data <= at_data;
			at_ready <= 1'b0;
			wait_q <= 4'h0;
		end
		else if (at_valid)
		begin
			wait_q <= wait_q + 4'h1;
			at_ready <= (wait_q + 4'h1 >= stall);
		end
	end
endmodule // trace_sink_model

//--- bench/trace_event_ctrl_tb.sv
// self-checking testbench of the trace event control block
`timescale 1ns/1ns
module trace_event_ctrl_tb;
	import evctl_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	reg_req_t req = '0;
	trace_in_t tin = '0;
	logic [6:0] src_id = 7'h2a;
	logic [31:0] rdata, ext_sel, at_data, got_data;
	logic [3:0] inst_ev;
	logic data_ev, lp_allow, at_valid, at_ready;
	logic [6:0] at_id, got_id;
	int n_got, n0;
	int miscompares = 0;
	int n_checks = 0;
	always #5 clk_sys = ~clk_sys;
	trace_event_ctrl u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata),
		.TRACE_IN(tin), .TRACE_SOURCE_ID(src_id), .INST_EVENT(inst_ev), .DATA_EVENT(data_ev),
		.LOW_POWER_ALLOW(lp_allow), .EXTIN_SELECT(ext_sel), .ATVALID(at_valid),
		.ATREADY(at_ready), .ATID(at_id), .ATDATA(at_data));
	trace_sink_model u_sink (.clk(clk_sys), .rst_n(rst_n), .at_valid(at_valid),
		.at_ready(at_ready), .at_id(at_id), .at_data(at_data), .stall(4'h3), .n_got(n_got),
		.got_id(got_id), .got_data(got_data));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk_sys);
		req.wr <= 1'b0;
	endtask
	task rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_sys);
		req.rd <= 1'b0;
		#1 check(what, rdata, exp);
	endtask
	task pulse(input logic [3:0] hit);
		@(posedge clk_sys);
		tin.event_hit <= hit;
		@(posedge clk_sys);
		tin.event_hit <= 4'h0;
		#1;
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_regs;
		wr_reg(OFS_EVENT_CTRL, 32'h0000_0000);
		#1 check("lp_allow", {31'h0, lp_allow}, 32'h1);
		wr_reg(OFS_EVENT_CTRL, 32'hffff_ffff);
		rd_chk("ctrl", OFS_EVENT_CTRL, 32'h0000_181f);
		check("lp_allow", {31'h0, lp_allow}, 32'h0);
		wr_reg(OFS_EXTIN_SEL, 32'ha5c3_1e7f);
		rd_chk("sel", OFS_EXTIN_SEL, 32'ha5c3_1e7f);
		check("ext_sel", ext_sel, 32'ha5c3_1e7f);
		rd_chk("unmapped", 12'h00c, 32'h0000_0000);
	endtask
	task t_busy;
		@(posedge clk_sys);
		tin.unit_busy <= 1'b1;
		wr_reg(OFS_EVENT_CTRL, 32'h0000_0000);
		wr_reg(OFS_EXTIN_SEL, 32'h0000_0000);
		@(posedge clk_sys);
		tin.unit_busy <= 1'b0;
		rd_chk("busy ctrl", OFS_EVENT_CTRL, 32'h0000_181f);
		rd_chk("busy sel", OFS_EXTIN_SEL, 32'ha5c3_1e7f);
	endtask
	task t_events;
		pulse(4'hf);
		check("inst", {28'h0, inst_ev}, 32'hf);
		check("data", {31'h0, data_ev}, 32'h1);
		pulse(4'he);
		check("inst", {28'h0, inst_ev}, 32'he);
		check("data", {31'h0, data_ev}, 32'h0);
		wr_reg(OFS_EVENT_CTRL, 32'h0000_0005);
		pulse(4'hf);
		check("inst", {28'h0, inst_ev}, 32'h5);
		check("data", {31'h0, data_ev}, 32'h0);
	endtask
	task t_trig;
		wr_reg(OFS_EVENT_CTRL, 32'h0000_0800);
		tin.overflow <= 1'b1;
		repeat (10) @(posedge clk_sys);
		n0 = n_got;
		pulse(4'h1);
		check("atvalid", {31'h0, at_valid}, 32'h1);
		check("atid", {25'h0, at_id}, 32'h7d);
		check("atdata", at_data, {25'h0, src_id});
		// second hit while the first is still pending
		pulse(4'h1);
		for (int i = 0; i < 20 && at_valid; i++)
			@(posedge clk_sys);
		#1 check("beats", n_got - n0, 32'h1);
		check("sunk data", got_data, {25'h0, src_id});
		check("sunk id", {25'h0, got_id}, 32'h7d);
		rd_chk("status", OFS_STATUS, 32'h0000_0002);
		pulse(4'h1);
		repeat (8) @(posedge clk_sys);
		#1 check("beats", n_got - n0, 32'h2);
	endtask
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs;
		t_busy;
		t_events;
		t_trig;
		end_of_test;
	end
	initial
	begin
		#20000;
		miscompares++;
		end_of_test;
	end
endmodule // trace_event_ctrl_tb
